// ==== common/sltc_pkg.sv ====
/*
  Shared constants for the serial link transmitter configuration block:
  configuration port map, field layout, reset values, lane framing and host registers.
  Assumes both ends and the bench import it.
*/
package sltc_pkg;
  localparam int CFG_ADDR_W = 8;
  localparam int CFG_DATA_W = 8;
  localparam int NUM_LANES  = 4;
  localparam int OCTET_W    = 8;
  localparam int SAMPLE_W   = 16;
  localparam int SCR_W      = 15;
  localparam int AVS_ADDR_W = 4;
  localparam int AVS_DATA_W = 32;

  localparam logic [CFG_ADDR_W-1:0] ADDR_LANE_CFG  = 8'h47;
  localparam logic [CFG_ADDR_W-1:0] ADDR_LINK_CTRL = 8'h60;
  localparam logic [CFG_DATA_W-1:0] LANE_CFG_RESET  = 8'h00;
  localparam logic [CFG_DATA_W-1:0] LINK_CTRL_RESET = 8'h7d;
  localparam logic [CFG_DATA_W-1:0] LANE_CFG_RSVD_MASK = 8'h88;

  localparam int SWING_HI     = 6;
  localparam int SWING_LO     = 4;
  localparam int DEEMPH_HI    = 2;
  localparam int DEEMPH_LO    = 0;
  localparam int SCRAMBLE_BIT = 7;
  localparam int K_HI         = 6;
  localparam int K_LO         = 2;
  localparam int LANES_BIT    = 1;
  localparam int ENABLE_BIT   = 0;

  localparam logic [4:0] K_MIN_SINGLE = 5'h08;
  localparam logic [4:0] K_MIN_DUAL   = 5'h10;

  localparam logic [OCTET_W-1:0] IDLE_OCTET = 8'h55;
  localparam logic [OCTET_W-1:0] SYNC_OCTET = 8'hbc;
  localparam logic [2:0]         BIT_LAST   = 3'h7;
  localparam logic [SCR_W-1:0]   SCR_SEED   = 15'h7fff;
  localparam int SCR_TAP_A = 13;
  localparam int SCR_TAP_B = 14;

  localparam logic [AVS_ADDR_W-1:0] AVS_CMD    = 4'h0;
  localparam logic [AVS_ADDR_W-1:0] AVS_STATUS = 4'h4;
  localparam int CMD_ADDR_LO    = 0;
  localparam int CMD_DATA_LO    = 8;
  localparam int CMD_WRITE_BIT  = 16;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_REFUSED   = 1;
  localparam int STAT_RDATA_LO  = 8;
  localparam int STAT_SHADOW_LO = 16;

  typedef enum logic [2:0] {
    DS_IDLE = 3'b001,
    DS_SYNC = 3'b010,
    DS_DATA = 3'b100
  } sltc_dev_state_t;

  typedef enum logic [1:0] {
    HS_IDLE = 2'b01,
    HS_BUSY = 2'b10
  } sltc_host_state_t;
endpackage

// ==== common/sltc_if.sv ====
/*
  Configuration port between the controller and the transmitter.
  Assumes one clock shared by both ends; the controller holds a request until the ack pulse.
*/
`timescale 1ns/100ps
interface sltc_if;
  import sltc_pkg::*;
  logic                  cfg_req;
  logic                  cfg_write;
  logic [CFG_ADDR_W-1:0] cfg_addr;
  logic [CFG_DATA_W-1:0] cfg_wdata;
  logic [CFG_DATA_W-1:0] cfg_rdata;
  logic                  cfg_ack;

  modport device (
    input  cfg_req,
    input  cfg_write,
    input  cfg_addr,
    input  cfg_wdata,
    output cfg_rdata,
    output cfg_ack
  );

  modport host (
    output cfg_req,
    output cfg_write,
    output cfg_addr,
    output cfg_wdata,
    input  cfg_rdata,
    input  cfg_ack
  );
endinterface

// ==== rtl/sltc_host.sv ====
/*
  Controller end: an Avalon-MM slave with command and status registers that issues
  configuration accesses to the transmitter and guards its programming constraints.
  Assumes ref_clk is shared with the transmitter and the Avalon master.
*/
`timescale 1ns/100ps
module sltc_host (
  input  wire logic                            ref_clk,
  input  wire logic                            reset_n,
  input  wire logic [sltc_pkg::AVS_ADDR_W-1:0] avs_address,
  input  wire logic                            avs_read,
  input  wire logic                            avs_write,
  input  wire logic [sltc_pkg::AVS_DATA_W-1:0] avs_writedata,
  output logic      [sltc_pkg::AVS_DATA_W-1:0] avs_readdata,
  output logic                                 avs_waitrequest,
  sltc_if.host                                 cfg
);
  import sltc_pkg::*;

  sltc_host_state_t      state, next_state;
  logic                  bus_wait, next_bus_wait;
  logic [AVS_DATA_W-1:0] rd_word, next_rd_word;
  logic                  req, next_req;
  logic                  cmd_write, next_cmd_write;
  logic [CFG_ADDR_W-1:0] cmd_addr, next_cmd_addr;
  logic [CFG_DATA_W-1:0] cmd_data, next_cmd_data;
  logic                  refused, next_refused;
  logic [CFG_DATA_W-1:0] last_rdata, next_last_rdata;
  logic [CFG_DATA_W-1:0] shadow, next_shadow;
  logic                  acc;
  logic                  bad;
  logic [CFG_ADDR_W-1:0] w_addr;
  logic [CFG_DATA_W-1:0] w_data;
  logic [4:0]            w_k;

  assign avs_waitrequest = bus_wait;
  assign avs_readdata    = rd_word;
  assign cfg.cfg_req     = req;
  assign cfg.cfg_write   = cmd_write;
  assign cfg.cfg_addr    = cmd_addr;
  assign cfg.cfg_wdata   = cmd_data;

  always_comb begin
    acc             = (avs_read || avs_write) && !bus_wait;
    next_bus_wait   = !((avs_read || avs_write) && bus_wait);
    next_rd_word    = rd_word;
    next_state      = state;
    next_req        = req;
    next_cmd_write  = cmd_write;
    next_cmd_addr   = cmd_addr;
    next_cmd_data   = cmd_data;
    next_refused    = refused;
    next_last_rdata = last_rdata;
    next_shadow     = shadow;
    w_addr          = avs_writedata[CMD_ADDR_LO +: CFG_ADDR_W];
    w_data          = avs_writedata[CMD_DATA_LO +: CFG_DATA_W];
    w_k             = w_data[K_HI:K_LO];
    bad             = 1'b0;
    if (avs_writedata[CMD_WRITE_BIT] && w_addr == ADDR_LANE_CFG) begin
      w_data = w_data & ~LANE_CFG_RSVD_MASK;
    end
    if (avs_writedata[CMD_WRITE_BIT] && w_addr == ADDR_LINK_CTRL) begin
      bad = (w_k < K_MIN_SINGLE)
          || (w_data[LANES_BIT] && w_k < K_MIN_DUAL)
          || (shadow[ENABLE_BIT] && w_data[CFG_DATA_W-1:LANES_BIT] != shadow[CFG_DATA_W-1:LANES_BIT]);
    end
    // Load in the wait cycle so read data stands when waitrequest drops
    if (avs_read && bus_wait) begin
      next_rd_word = '0;
      if (avs_address == AVS_STATUS) begin
        next_rd_word[STAT_BUSY_BIT]                 = req;
        next_rd_word[STAT_REFUSED]                  = refused;
        next_rd_word[STAT_RDATA_LO +: CFG_DATA_W]  = last_rdata;
        next_rd_word[STAT_SHADOW_LO +: CFG_DATA_W] = shadow;
      end else if (avs_address == AVS_CMD) begin
        next_rd_word[CMD_ADDR_LO +: CFG_ADDR_W] = cmd_addr;
        next_rd_word[CMD_DATA_LO +: CFG_DATA_W] = cmd_data;
        next_rd_word[CMD_WRITE_BIT]             = cmd_write;
      end
    end
    unique case (state)
      HS_IDLE: begin
        if (acc && avs_write && avs_address == AVS_CMD) begin
          if (bad) begin
            next_refused = 1'b1;
          end else begin
            next_refused   = 1'b0;
            next_state     = HS_BUSY;
            next_req       = 1'b1;
            next_cmd_write = avs_writedata[CMD_WRITE_BIT];
            next_cmd_addr  = w_addr;
            next_cmd_data  = w_data;
          end
        end
      end
      HS_BUSY: begin
        if (acc && avs_write && avs_address == AVS_CMD) begin
          next_refused = 1'b1;
        end
        if (cfg.cfg_ack) begin
          next_state = HS_IDLE;
          next_req   = 1'b0;
          if (!cmd_write) begin
            next_last_rdata = cfg.cfg_rdata;
          end
          if (cmd_addr == ADDR_LINK_CTRL) begin
            next_shadow = cmd_write ? cmd_data : cfg.cfg_rdata;
          end
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state      <= HS_IDLE;
      bus_wait   <= 1'b1;
      rd_word    <= '0;
      req        <= 1'b0;
      cmd_write  <= 1'b0;
      cmd_addr   <= '0;
      cmd_data   <= '0;
      refused    <= 1'b0;
      last_rdata <= '0;
      shadow     <= LINK_CTRL_RESET;
    end else begin
      state      <= next_state;
      bus_wait   <= next_bus_wait;
      rd_word    <= next_rd_word;
      req        <= next_req;
      cmd_write  <= next_cmd_write;
      cmd_addr   <= next_cmd_addr;
      cmd_data   <= next_cmd_data;
      refused    <= next_refused;
      last_rdata <= next_last_rdata;
      shadow     <= next_shadow;
    end
  end
endmodule

// ==== rtl/sltc_device.sv ====
/*
  Transmitter end: the two configuration registers, lane driver settings and a
  four-lane serial framer that sends idle, sync or sample octets.
  Assumes samples come from logic on ref_clk and the controller holds each request until ack.
*/
// Our own choice: the Avalon-MM register port.
`timescale 1ns/100ps
module sltc_device (
  input  wire logic                          ref_clk,
  input  wire logic                          reset_n,
  sltc_if.device                             cfg,
  input  wire logic [sltc_pkg::SAMPLE_W-1:0] sample_a,
  input  wire logic [sltc_pkg::SAMPLE_W-1:0] sample_b,
  output logic                               sample_take,
  output logic      [sltc_pkg::NUM_LANES-1:0] lane_tx,
  output logic      [2:0]                    tx_swing_sel,
  output logic      [2:0]                    tx_deemph_sel,
  output logic                               link_up
);
  import sltc_pkg::*;

  function automatic logic [OCTET_W-1:0] lane_octet(
    input logic [1:0]          lane,
    input logic                dual,
    input logic                second,
    input logic                sync,
    input logic [SAMPLE_W-1:0] a,
    input logic [SAMPLE_W-1:0] b
  );
    logic [SAMPLE_W-1:0] s;
    logic                lo;
    s  = lane[1] ? b : a;
    lo = dual ? lane[0] : second;
    if (!dual && lane[0]) begin
      lane_octet = IDLE_OCTET;
    end else if (sync) begin
      lane_octet = SYNC_OCTET;
    end else begin
      lane_octet = lo ? s[OCTET_W-1:0] : s[SAMPLE_W-1:OCTET_W];
    end
  endfunction

  // Configuration registers
  logic [CFG_DATA_W-1:0] lane_cfg, next_lane_cfg;
  logic [CFG_DATA_W-1:0] link_ctrl, next_link_ctrl;
  logic [CFG_DATA_W-1:0] rdata, next_rdata;
  logic                  ack, next_ack;

  assign cfg.cfg_rdata = rdata;
  assign cfg.cfg_ack   = ack;
  assign tx_swing_sel  = lane_cfg[SWING_HI:SWING_LO];
  assign tx_deemph_sel = lane_cfg[DEEMPH_HI:DEEMPH_LO];

  always_comb begin
    next_lane_cfg  = lane_cfg;
    next_link_ctrl = link_ctrl;
    next_rdata     = rdata;
    next_ack       = cfg.cfg_req && !ack;
    if (cfg.cfg_req && !ack) begin
      if (cfg.cfg_write) begin
        if (cfg.cfg_addr == ADDR_LANE_CFG) begin
          next_lane_cfg = cfg.cfg_wdata;
        end else if (cfg.cfg_addr == ADDR_LINK_CTRL) begin
          next_link_ctrl = cfg.cfg_wdata;
        end
      end else begin
        if (cfg.cfg_addr == ADDR_LANE_CFG) begin
          next_rdata = lane_cfg;
        end else if (cfg.cfg_addr == ADDR_LINK_CTRL) begin
          next_rdata = link_ctrl;
        end else begin
          next_rdata = '0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      lane_cfg  <= LANE_CFG_RESET;
      link_ctrl <= LINK_CTRL_RESET;
      rdata     <= '0;
      ack       <= 1'b0;
    end else begin
      lane_cfg  <= next_lane_cfg;
      link_ctrl <= next_link_ctrl;
      rdata     <= next_rdata;
      ack       <= next_ack;
    end
  end

  // Framer state
  sltc_dev_state_t     state, next_state;
  logic [2:0]          bit_cnt, next_bit_cnt;
  logic                octet_cnt, next_octet_cnt;
  logic [4:0]          frame_cnt, next_frame_cnt;
  logic                act_scramble, next_act_scramble;
  logic [4:0]          act_k, next_act_k;
  logic                act_dual, next_act_dual;
  logic [SAMPLE_W-1:0] hold_a, next_hold_a;
  logic [SAMPLE_W-1:0] hold_b, next_hold_b;
  logic                take, next_take;
  logic                up, next_up;
  logic                boundary;
  logic                frame_end;
  logic                mf_end;
  logic                load_sync;
  logic                load_data;
  logic [SAMPLE_W-1:0] src_a;
  logic [SAMPLE_W-1:0] src_b;

  assign sample_take = take;
  assign link_up     = up;

  always_comb begin
    boundary          = bit_cnt == BIT_LAST;
    frame_end         = act_dual || octet_cnt;
    mf_end            = frame_end && frame_cnt == act_k;
    next_state        = state;
    next_bit_cnt      = 3'(bit_cnt + 3'h1);
    next_octet_cnt    = octet_cnt;
    next_frame_cnt    = frame_cnt;
    next_act_scramble = act_scramble;
    next_act_k        = act_k;
    next_act_dual     = act_dual;
    next_up           = up;
    next_hold_a       = hold_a;
    next_hold_b       = hold_b;
    next_take         = 1'b0;
    load_sync         = 1'b0;
    load_data         = 1'b0;
    if (boundary && state != DS_IDLE) begin
      next_octet_cnt = frame_end ? 1'b0 : 1'b1;
      if (frame_end) begin
        next_frame_cnt = mf_end ? 5'h00 : 5'(frame_cnt + 5'h01);
      end
    end
    unique case (state)
      DS_IDLE: begin
        if (boundary && link_ctrl[ENABLE_BIT]) begin
          next_state        = DS_SYNC;
          next_act_scramble = link_ctrl[SCRAMBLE_BIT];
          next_act_k        = link_ctrl[K_HI:K_LO];
          next_act_dual     = link_ctrl[LANES_BIT];
          next_octet_cnt    = 1'b0;
          next_frame_cnt    = 5'h00;
          load_sync         = 1'b1;
        end
      end
      DS_SYNC: begin
        if (boundary) begin
          if (!link_ctrl[ENABLE_BIT]) begin
            next_state = DS_IDLE;
          end else if (mf_end) begin
            next_state = DS_DATA;
            next_up    = 1'b1;
            load_data  = 1'b1;
          end else begin
            load_sync = 1'b1;
          end
        end
      end
      DS_DATA: begin
        if (boundary) begin
          if (!link_ctrl[ENABLE_BIT]) begin
            next_state = DS_IDLE;
            next_up    = 1'b0;
          end else begin
            load_data = 1'b1;
          end
        end
      end
    endcase
    if (next_state == DS_IDLE && state != DS_IDLE && boundary) begin
      next_octet_cnt = 1'b0;
      next_frame_cnt = 5'h00;
    end
    src_a = hold_a;
    src_b = hold_b;
    if (load_data && !next_octet_cnt) begin
      src_a       = sample_a;
      src_b       = sample_b;
      next_hold_a = sample_a;
      next_hold_b = sample_b;
      next_take   = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state        <= DS_IDLE;
      bit_cnt      <= 3'h0;
      octet_cnt    <= 1'b0;
      frame_cnt    <= 5'h00;
      act_scramble <= 1'b0;
      act_k        <= 5'h00;
      act_dual     <= 1'b0;
      hold_a       <= '0;
      hold_b       <= '0;
      take         <= 1'b0;
      up           <= 1'b0;
    end else begin
      state        <= next_state;
      bit_cnt      <= next_bit_cnt;
      octet_cnt    <= next_octet_cnt;
      frame_cnt    <= next_frame_cnt;
      act_scramble <= next_act_scramble;
      act_k        <= next_act_k;
      act_dual     <= next_act_dual;
      hold_a       <= next_hold_a;
      hold_b       <= next_hold_b;
      take         <= next_take;
      up           <= next_up;
    end
  end

  // Per-lane shifter and self-synchronous scrambler
  for (genvar i = 0; i < NUM_LANES; i++) begin : g_lane
    logic [OCTET_W-1:0] shift, next_shift;
    logic [SCR_W-1:0]   scr, next_scr;
    logic               bit_out, next_bit_out;
    logic               scr_now;
    logic               s;

    assign lane_tx[i] = bit_out;

    always_comb begin
      scr_now      = state == DS_DATA && act_scramble && (act_dual || (i % 2) == 0);
      s            = shift[OCTET_W-1] ^ scr[SCR_TAP_A] ^ scr[SCR_TAP_B];
      next_bit_out = scr_now ? s : shift[OCTET_W-1];
      next_scr     = scr_now ? {scr[SCR_W-2:0], s} : SCR_SEED;
      next_shift   = {shift[OCTET_W-2:0], 1'b0};
      if (boundary) begin
        if (load_sync || load_data) begin
          next_shift = lane_octet(2'(i), next_act_dual, next_octet_cnt, load_sync, src_a, src_b);
        end else begin
          next_shift = IDLE_OCTET;
        end
      end
    end

    always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
        shift   <= IDLE_OCTET;
        scr     <= SCR_SEED;
        bit_out <= 1'b0;
      end else begin
        shift   <= next_shift;
        scr     <= next_scr;
        bit_out <= next_bit_out;
      end
    end
  end
endmodule

// ==== bench/sltc_properties.sv ====
/*
  Checker for the configuration port that joins controller and transmitter.
  Assumes it is instantiated beside the interface, on the shared clock and reset.
*/
`timescale 1ns/100ps
module sltc_properties (
  input wire logic                            ref_clk,
  input wire logic                            reset_n,
  input wire logic                            cfg_req,
  input wire logic                            cfg_write,
  input wire logic [sltc_pkg::CFG_ADDR_W-1:0] cfg_addr,
  input wire logic [sltc_pkg::CFG_DATA_W-1:0] cfg_wdata,
  input wire logic [sltc_pkg::CFG_DATA_W-1:0] cfg_rdata,
  input wire logic                            cfg_ack
);
  import sltc_pkg::*;
  logic [CFG_DATA_W-1:0] link_shadow;
  logic [CFG_DATA_W-1:0] next_link_shadow;
  logic [CFG_DATA_W-1:0] lane_shadow;
  logic [CFG_DATA_W-1:0] next_lane_shadow;
  logic                  wr_link;
  logic                  wr_lane;
  logic                  rd_link;
  logic                  rd_lane;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  assign wr_link = cfg_req && cfg_write && cfg_addr == ADDR_LINK_CTRL;
  assign wr_lane = cfg_req && cfg_write && cfg_addr == ADDR_LANE_CFG;
  assign rd_link = cfg_req && !cfg_write && cfg_addr == ADDR_LINK_CTRL;
  assign rd_lane = cfg_req && !cfg_write && cfg_addr == ADDR_LANE_CFG;
  // Register contents as the port has written them
  always_comb begin
    next_link_shadow = link_shadow;
    next_lane_shadow = lane_shadow;
    if (cfg_ack && wr_link) next_link_shadow = cfg_wdata;
    if (cfg_ack && wr_lane) next_lane_shadow = cfg_wdata;
  end
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      link_shadow <= LINK_CTRL_RESET;
      lane_shadow <= LANE_CFG_RESET;
    end else begin
      link_shadow <= next_link_shadow;
      lane_shadow <= next_lane_shadow;
    end
  end
  property p_ack_timely;
    cfg_req && !cfg_ack |=> cfg_ack ##1 !cfg_ack;
  endproperty
  property p_req_hold;
    cfg_req && !cfg_ack |=> cfg_req && $stable(cfg_addr) && $stable(cfg_write) && $stable(cfg_wdata);
  endproperty
  property p_ack_cause;
    cfg_ack |-> $past(cfg_req);
  endproperty
  property p_rsvd_zero;
    wr_lane |-> (cfg_wdata & LANE_CFG_RSVD_MASK) == 8'h00;
  endproperty
  property p_k_min;
    wr_link |-> cfg_wdata[K_HI:K_LO] >= K_MIN_SINGLE;
  endproperty
  property p_dual_k;
    wr_link && cfg_wdata[LANES_BIT] |-> cfg_wdata[K_HI:K_LO] >= K_MIN_DUAL;
  endproperty
  property p_enable_guard;
    wr_link && link_shadow[ENABLE_BIT] |-> cfg_wdata[7:1] == link_shadow[7:1];
  endproperty
  property p_link_readback;
    cfg_ack && rd_link |-> cfg_rdata == link_shadow;
  endproperty
  property p_lane_readback;
    cfg_ack && rd_lane |-> cfg_rdata == lane_shadow;
  endproperty
  property p_unmapped;
    cfg_ack && !cfg_write && !rd_link && !rd_lane |-> cfg_rdata == 8'h00;
  endproperty
  a_ack_timely: assert property (p_ack_timely) else $error("config ack late or long");
  a_req_hold: assert property (p_req_hold) else $error("config request changed before ack");
  a_ack_cause: assert property (p_ack_cause) else $error("config ack without request");
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved lane bits written as one");
  a_k_min: assert property (p_k_min) else $error("frame code below minimum written");
  a_dual_k: assert property (p_dual_k) else $error("dual lane with short multiframe");
  a_enable_guard: assert property (p_enable_guard) else $error("link parameters changed while on");
  a_link_readback: assert property (p_link_readback) else $error("link control readback wrong");
  a_lane_readback: assert property (p_lane_readback) else $error("lane config readback wrong");
  a_unmapped: assert property (p_unmapped) else $error("unmapped config read not zero");
  c_link_read: cover property (cfg_ack && rd_link);
  c_dual_write: cover property (cfg_ack && wr_link && cfg_wdata[LANES_BIT]);
  c_lane_write: cover property (cfg_ack && wr_lane);
endmodule

// ==== bench/test_serial_link_tx_config.sv ====
/*
  Testbench: drives the controller over Avalon-MM and watches the transmitter lanes.
  Assumes both ends share one 125 MHz clock and a synchronous active-low reset.
*/
`timescale 1ns/100ps
module test_serial_link_tx_config;
  import sltc_pkg::*;
  logic                  ref_clk;
  logic                  reset_n;
  logic [AVS_ADDR_W-1:0] avs_address;
  logic                  avs_read;
  logic                  avs_write;
  logic                  avs_waitrequest;
  logic [AVS_DATA_W-1:0] avs_writedata;
  logic [AVS_DATA_W-1:0] avs_readdata;
  logic [AVS_DATA_W-1:0] st;
  logic [SAMPLE_W-1:0]   sample_a = 16'h1234;
  logic [SAMPLE_W-1:0]   exp_a;
  logic [7:0]            got_hi;
  logic [7:0]            got_lo;
  logic [SAMPLE_W-1:0]   sample_b;
  logic                  sample_take;
  logic                  link_up;
  logic [NUM_LANES-1:0]  lane_tx;
  logic [NUM_LANES-1:0]  prev_lanes;
  logic [2:0]            tx_swing_sel;
  logic [2:0]            tx_deemph_sel;
  logic [7:0]            kv [5] = '{8'h1c, 8'h3e, 8'h20, 8'h42, 8'hc2};
  logic [7:0]            kr [5] = '{8'h7c, 8'h7c, 8'h20, 8'h42, 8'hc2};
  int                    mismatches;
  int                    checks_done;
  int                    cycles;
  int                    n;
  sltc_if sltc_if_i ();
  sltc_host sltc_host_i (.ref_clk(ref_clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cfg(sltc_if_i));
  sltc_device sltc_device_i (.ref_clk(ref_clk), .reset_n(reset_n), .cfg(sltc_if_i), .sample_a(sample_a),
    .sample_b(sample_b), .sample_take(sample_take), .lane_tx(lane_tx), .tx_swing_sel(tx_swing_sel),
    .tx_deemph_sel(tx_deemph_sel), .link_up(link_up));
  sltc_properties sltc_properties_i (.ref_clk(ref_clk), .reset_n(reset_n), .cfg_req(sltc_if_i.cfg_req),
    .cfg_write(sltc_if_i.cfg_write), .cfg_addr(sltc_if_i.cfg_addr), .cfg_wdata(sltc_if_i.cfg_wdata),
    .cfg_rdata(sltc_if_i.cfg_rdata), .cfg_ack(sltc_if_i.cfg_ack));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (sample_take === 1'b1) sample_a <= sample_a + 16'h0101;
    if (cycles == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish;
    if (mismatches == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic avs(input logic wr, input logic [AVS_ADDR_W-1:0] a, input logic [AVS_DATA_W-1:0] d);
    int k;
    k = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge ref_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 100);
    if (k >= 100) mismatches++;
    st = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask
  // Issue one configuration command and poll until the controller is idle
  task automatic cmd(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    avs(1'b1, AVS_CMD, {15'h0000, wr, d, a});
    do begin
      avs(1'b0, AVS_STATUS, 32'h0);
      k++;
    end while (st[STAT_BUSY_BIT] !== 1'b0 && k < 50);
    if (k >= 50) mismatches++;
  endtask
  task automatic expect_cfg(input logic [7:0] a, input logic [7:0] exp, input string what);
    cmd(1'b0, a, 8'h00);
    chk(what, {24'h0, exp}, {24'h0, st[STAT_RDATA_LO+:8]});
  endtask
  task automatic wait_up(output int c);
    c = 0;
    while (link_up !== 1'b1 && c < 1000) begin
      @(posedge ref_clk);
      c++;
    end
  endtask
  initial begin
    mismatches = 0;
    checks_done = 0;
    cycles = 0;
    reset_n = 1'b0;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    sample_b = 16'hfedc;
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    wait_up(n);
    chk("single lane sync length", 32'h1, {31'h0, n >= 512 && n <= 540});
    avs(1'b0, AVS_STATUS, 32'h0);
    chk("shadow after reset", 32'h7d, {24'h0, st[STAT_SHADOW_LO+:8]});
    expect_cfg(ADDR_LINK_CTRL, 8'h7d, "link control reset");
    expect_cfg(ADDR_LANE_CFG, 8'h00, "lane config reset");
    avs(1'b0, 4'h8, 32'h0);
    chk("unmapped avalon read", 32'h0, st);
    cmd(1'b1, ADDR_LINK_CTRL, 8'hfd);
    chk("refused while enabled", 32'h1, {31'h0, st[STAT_REFUSED]});
    expect_cfg(ADDR_LINK_CTRL, 8'h7d, "kept while enabled");
    cmd(1'b1, ADDR_LINK_CTRL, 8'h7c);
    repeat (20) @(posedge ref_clk);
    chk("link down when disabled", 32'h0, {31'h0, link_up});
    prev_lanes = lane_tx;
    chk("idle lanes in step", 32'h1, {31'h0, prev_lanes === 4'h0 || prev_lanes === 4'hf});
    for (int i = 0; i < 16; i++) begin
      @(posedge ref_clk);
      chk("idle alternation", {28'h0, ~prev_lanes}, {28'h0, lane_tx});
      prev_lanes = lane_tx;
    end
    for (int c = 0; c < 8; c++) begin
      cmd(1'b1, ADDR_LANE_CFG, {1'b1, 3'(c), 1'b1, 3'(7 - c)});
      expect_cfg(ADDR_LANE_CFG, {1'b0, 3'(c), 1'b0, 3'(7 - c)}, "lane config readback");
      chk("swing select", 32'(c), {29'h0, tx_swing_sel});
      chk("de-emphasis select", 32'(7 - c), {29'h0, tx_deemph_sel});
    end
    for (int i = 0; i < 5; i++) begin
      cmd(1'b1, ADDR_LINK_CTRL, kv[i]);
      chk("refusal flag", {31'h0, i < 2}, {31'h0, st[STAT_REFUSED]});
      expect_cfg(ADDR_LINK_CTRL, kr[i], "link control after write");
    end
    cmd(1'b1, ADDR_LINK_CTRL, 8'hc3);
    wait_up(n);
    chk("dual lane resync length", 32'h1, {31'h0, n >= 100 && n <= 160});
    // Disable, then enable dual lane without scrambling and follow one frame
    cmd(1'b1, ADDR_LINK_CTRL, 8'hc2);
    cmd(1'b1, ADDR_LINK_CTRL, 8'h43);
    wait_up(n);
    chk("link up unscrambled", 32'h1, {31'h0, link_up});
    do begin
      @(posedge ref_clk);
    end while (sample_take !== 1'b1);
    exp_a = sample_a;
    for (int i = 7; i >= 0; i--) begin
      @(posedge ref_clk);
      got_hi[i] = lane_tx[0];
      got_lo[i] = lane_tx[1];
    end
    chk("dual lane data", {16'h0, exp_a}, {16'h0, got_hi, got_lo});
    n = 0;
    repeat (64) begin
      @(posedge ref_clk);
      if (sample_take === 1'b1) n++;
    end
    chk("dual lane sample rate", 32'h8, 32'(n));
    expect_cfg(8'h50, 8'h00, "unmapped config read");
    tally_and_finish();
  end
endmodule
